// >>> verilog/pcr_pkg.sv
/*
 * constants of the clock-generator control register bank: register
 * addresses, widths, reset values, field positions and serial framing.
 * assumes a single mclk domain; all input pins are synchronised inside the register bank.
 */
// Summary of operation
// - divisor field sets feedback counter ratio 9..4103
// - post divider selects divide by 1, 2, 4
// - coarse codes 00..11 add 1..4 clocks
// - fine code n gives (n+1)/16 clock delay
// - pump codes 00, 10, 11 select three currents
// - pump code 01 behaves exactly like 00
// - three polarity bits, one means positive
// - readback bit shifts registers out serially
// - synthesizer enable switches counter, post divider, output clocks and delay line on/off
// - cleared bypass bit counts external test clock
// - seven enables gate seven TTL outputs
// - readback shows seven registers 8,4,7,7,3,8,4 bits
// - PECL always driven, TTL only when enabled
package pcr_pkg;

  // register addresses carried in the first three bits of a frame
  localparam logic [2:0] ADDR_DIV_LOW = 3'h1;
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h2;
  localparam logic [2:0] ADDR_CENTER = 3'h3;
  localparam logic [2:0] ADDR_DELAY = 3'h4;
  localparam logic [2:0] ADDR_PUMP = 3'h5;
  localparam logic [2:0] ADDR_OUTPOL = 3'h6;
  localparam logic [2:0] ADDR_TESTPOW = 3'h7;
  localparam int ADDR_BITS = 3;

  // register widths
  localparam int W_DIV_LOW = 8;
  localparam int W_DIV_HIGH = 4;
  localparam int W_CENTER = 7;
  localparam int W_DELAY = 7;
  localparam int W_PUMP = 3;
  localparam int W_OUTPOL = 8;
  localparam int W_TESTPOW = 4;
  localparam int READBACK_BITS = 41;

  // reset values: normal operating settings
  localparam logic [7:0] RST_DIV_LOW = 8'h38;
  localparam logic [3:0] RST_DIV_HIGH = 4'h5;
  localparam logic [6:0] RST_CENTER = 7'h5f;
  localparam logic [6:0] RST_DELAY = 7'h10;
  localparam logic [2:0] RST_PUMP = 3'h4;
  localparam logic [7:0] RST_OUTPOL = 8'h03;
  localparam logic [3:0] RST_TESTPOW = 4'h7;

  // field positions
  localparam int CEN_DIV_HI = 6;
  localparam int CEN_DIV_LO = 5;
  localparam int CEN_BAND_HI = 4;
  localparam int DLY_COARSE_HI = 6;
  localparam int DLY_COARSE_LO = 5;
  localparam int DLY_FINE_HI = 4;
  localparam int PUMP_CUR_HI = 2;
  localparam int PUMP_CUR_LO = 1;
  localparam int PUMP_EN_TEST = 0;
  localparam int OP_EN_UNLOCK = 7;
  localparam int OP_EN_DELAYED_SYNC_OUT = 6;
  localparam int OP_EN_HALF = 5;
  localparam int OP_EN_HALF_N = 4;
  localparam int OP_EN_FULL = 3;
  localparam int OP_EN_FULL_N = 2;
  localparam int OP_POL_DELAYED_SYNC_OUT = 1;
  localparam int OP_POL_SYNC = 0;
  localparam int TP_READBACK = 3;
  localparam int TP_SYNTHESIZER_ENABLE = 2;
  localparam int TP_BYPASS = 1;
  localparam int TP_POL_PD = 0;

  // divider and pump encodings and ratio limits
  localparam logic [12:0] RATIO_OFFSET = 13'h0008;
  localparam logic [12:0] RATIO_MIN = 13'h0009;
  localparam logic [1:0] POST_DIV1 = 2'h0;
  localparam logic [1:0] POST_DIV2 = 2'h1;
  localparam logic [1:0] PUMP_UNUSED = 2'h1;
  localparam logic [1:0] PUMP_LOW = 2'h0;

endpackage

// >>> verilog/pcr_prog_counter.sv
/*
 * programmable feedback counter: divides a tick stream by a ratio.
 * assumes tick is a one-cycle pulse on mclk and ratio is at least 2.
 */
`timescale 1ns/100ps
module pcr_prog_counter #(
  parameter int WIDTH = 13
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic tick,
  input wire logic [WIDTH-1:0] ratio,
  // result
  output logic terminalPulse,
  output logic testOut
);

  logic [WIDTH-1:0] countQ;
  logic pulseQ;
  logic testQ;

  // count down from ratio-1; reloading keeps a new ratio glitch-free
  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      countQ <= '0;
      pulseQ <= 1'b0;
    end else if (tick) begin
      if (countQ == '0) begin
        countQ <= ratio - WIDTH'(1);
        pulseQ <= 1'b1;
      end else begin
        countQ <= countQ - WIDTH'(1);
        pulseQ <= 1'b0;
      end
    end else begin
      pulseQ <= 1'b0;
    end
  end

  // test output toggles once per full count
  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      testQ <= 1'b0;
    end else if (pulseQ) begin
      testQ <= ~testQ;
    end
  end

  assign terminalPulse = pulseQ;
  assign testOut = testQ;

endmodule

// >>> verilog/pcr_control_regs.sv
/*
 * control register bank of a line-locked clock generator with its
 * three-line serial write port, serial readback and digital outputs.
 * assumes serial pins, sync and test inputs are asynchronous to mclk
 * and toggle well below half the mclk rate.
 */
`timescale 1ns/100ps
module pcr_control_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // serial bus pins
  input wire logic serialClock,
  input wire logic serialData,
  input wire logic serialFrameEnable,
  output logic serialReadbackOut,
  output logic serialReadbackOe,
  // timing inputs
  input wire logic syncIn,
  input wire logic oscillatorTestIn,
  input wire logic unlockIn,
  // analogue settings
  output logic [12:0] divideRatio,
  output logic [1:0] pumpCurrent,
  output logic [4:0] centerBand,
  output logic [4:0] fineDelayCode,
  output logic phaseDetectorPolarity,
  output logic synthesizerEnable,
  output logic feedbackPulse,
  // PECL outputs
  output logic peclFullRate,
  output logic peclFullRateN,
  output logic peclHalfRate,
  output logic peclHalfRateN,
  output logic peclDelayedSync,
  output logic peclDelayedSyncN,
  // TTL outputs with enables
  output logic counterTestOut,
  output logic counterTestOe,
  output logic unlockOut,
  output logic unlockOe,
  output logic delayedSyncOut,
  output logic delayedSyncOe,
  output logic halfRateClockOut,
  output logic halfRateClockOe,
  output logic halfRateClockOutInverted,
  output logic halfRateClockInvOe,
  output logic fullRateClockOut,
  output logic fullRateClockOe,
  output logic fullRateClockOutInverted,
  output logic fullRateClockInvOe
);

  logic [5:0] metaQ;
  logic [5:0] pinQ;
  logic sclkPrevQ;
  logic framePrevQ;
  logic oscPrevQ;
  logic sclkRise;
  logic frameFall;
  logic frameRise;
  logic [3:0] bitCntQ;
  logic [2:0] addrQ;
  logic [7:0] dataQ;
  logic [7:0] divLowQ;
  logic [3:0] divHighQ;
  logic [6:0] centerQ;
  logic [6:0] delayQ;
  logic [2:0] pumpQ;
  logic [7:0] outPolQ;
  logic [3:0] testPowQ;
  logic [3:0] needBits;
  logic [40:0] rbShiftQ;
  logic [40:0] allRegs;
  logic [12:0] ratioSum;
  logic oscTick;
  logic [1:0] postCntQ;
  logic [1:0] postLimit;
  logic clkTick;
  logic fullQ;
  logic halfQ;
  logic [3:0] delayLineQ;
  logic dsyncQ;
  logic syncLevel;
  logic testOut;
  logic synthOn;

  // two-flop synchronisers: only pinQ is read downstream
  always_ff @(posedge mclk) begin
    if (rst) begin
      metaQ <= 6'h00;
      pinQ <= 6'h00;
    end else begin
      metaQ <= {unlockIn, oscillatorTestIn, syncIn, serialFrameEnable,
                serialData, serialClock};
      pinQ <= metaQ;
    end
  end

  // edge history of the synchronised pins
  always_ff @(posedge mclk) begin
    if (rst) begin
      sclkPrevQ <= 1'b0;
      framePrevQ <= 1'b0;
      oscPrevQ <= 1'b0;
    end else begin
      sclkPrevQ <= pinQ[0];
      framePrevQ <= pinQ[2];
      oscPrevQ <= pinQ[4];
    end
  end

  assign sclkRise = pinQ[0] & ~sclkPrevQ;
  assign frameRise = pinQ[2] & ~framePrevQ;
  assign frameFall = ~pinQ[2] & framePrevQ;

  // frame shifter: three address bits then data, msb first
  always_ff @(posedge mclk) begin
    if (rst || frameRise) begin
      bitCntQ <= 4'h0;
      addrQ <= 3'h0;
      dataQ <= 8'h00;
    end else if (pinQ[2] && sclkRise) begin
      if (bitCntQ != 4'hf) begin
        bitCntQ <= bitCntQ + 4'h1;
      end
      if (bitCntQ < 4'(pcr_pkg::ADDR_BITS)) begin
        addrQ <= {addrQ[1:0], pinQ[1]};
      end else begin
        dataQ <= {dataQ[6:0], pinQ[1]};
      end
    end
  end

  // bits a frame must carry for its address; short frames are dropped
  always_comb begin
    needBits = 4'hf;
    unique case (addrQ)
      pcr_pkg::ADDR_DIV_LOW: needBits = 4'(3 + pcr_pkg::W_DIV_LOW);
      pcr_pkg::ADDR_DIV_HIGH: needBits = 4'(3 + pcr_pkg::W_DIV_HIGH);
      pcr_pkg::ADDR_CENTER: needBits = 4'(3 + pcr_pkg::W_CENTER);
      pcr_pkg::ADDR_DELAY: needBits = 4'(3 + pcr_pkg::W_DELAY);
      pcr_pkg::ADDR_PUMP: needBits = 4'(3 + pcr_pkg::W_PUMP);
      pcr_pkg::ADDR_OUTPOL: needBits = 4'(3 + pcr_pkg::W_OUTPOL);
      pcr_pkg::ADDR_TESTPOW: needBits = 4'(3 + pcr_pkg::W_TESTPOW);
      default: needBits = 4'hf;
    endcase
  end

  // registers latch the last received bits when the frame closes
  always_ff @(posedge mclk) begin
    if (rst) begin
      divLowQ <= pcr_pkg::RST_DIV_LOW;
      divHighQ <= pcr_pkg::RST_DIV_HIGH;
      centerQ <= pcr_pkg::RST_CENTER;
      delayQ <= pcr_pkg::RST_DELAY;
      pumpQ <= pcr_pkg::RST_PUMP;
      outPolQ <= pcr_pkg::RST_OUTPOL;
      testPowQ <= pcr_pkg::RST_TESTPOW;
    end else if (frameFall && bitCntQ >= needBits) begin
      unique case (addrQ)
        pcr_pkg::ADDR_DIV_LOW: divLowQ <= dataQ;
        pcr_pkg::ADDR_DIV_HIGH: divHighQ <= dataQ[3:0];
        pcr_pkg::ADDR_CENTER: centerQ <= dataQ[6:0];
        pcr_pkg::ADDR_DELAY: delayQ <= dataQ[6:0];
        pcr_pkg::ADDR_PUMP: pumpQ <= dataQ[2:0];
        pcr_pkg::ADDR_OUTPOL: outPolQ <= dataQ;
        pcr_pkg::ADDR_TESTPOW: testPowQ <= dataQ[3:0];
        default: ;
      endcase
    end
  end

  // readback image in register order, each msb first
  assign allRegs = {divLowQ, divHighQ, centerQ, delayQ, pumpQ, outPolQ,
                    testPowQ};

  // rotate out on serial clock edges outside frames; reloads while readback is off
  // or a frame is open, so a scan starts at register one from the contents held before the last frame closed
  always_ff @(posedge mclk) begin
    if (rst) begin
      rbShiftQ <= 41'h0;
    end else if (!testPowQ[pcr_pkg::TP_READBACK] || pinQ[2]) begin
      rbShiftQ <= allRegs;
    end else if (sclkRise) begin
      rbShiftQ <= {rbShiftQ[39:0], rbShiftQ[40]};
    end
  end

  assign serialReadbackOut = rbShiftQ[40];
  assign serialReadbackOe = testPowQ[pcr_pkg::TP_READBACK];

  // feedback ratio: code plus offset, never below the minimum
  assign ratioSum = {1'b0, divHighQ, divLowQ} + pcr_pkg::RATIO_OFFSET;
  assign divideRatio = (ratioSum < pcr_pkg::RATIO_MIN) ?
                       pcr_pkg::RATIO_MIN : ratioSum;

  assign synthOn = testPowQ[pcr_pkg::TP_SYNTHESIZER_ENABLE];
  assign synthesizerEnable = synthOn;

  // bypass cleared: count the external test clock instead of mclk
  assign oscTick = testPowQ[pcr_pkg::TP_BYPASS] ? 1'b1 :
                   (pinQ[4] & ~oscPrevQ);

  pcr_prog_counter #(
    .WIDTH(13)
  ) u_counter (
    .mclk(mclk),
    .rst(rst),
    .run(synthOn),
    .tick(clkTick),
    .ratio(divideRatio),
    .terminalPulse(feedbackPulse),
    .testOut(testOut)
  );

  // post divider limit: one tick in 1, 2 or 4 becomes a clock tick
  always_comb begin
    unique case (centerQ[pcr_pkg::CEN_DIV_HI:pcr_pkg::CEN_DIV_LO])
      pcr_pkg::POST_DIV1: postLimit = 2'h0;
      pcr_pkg::POST_DIV2: postLimit = 2'h1;
      default: postLimit = 2'h3;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst || !synthOn) begin
      postCntQ <= 2'h0;
    end else if (oscTick) begin
      postCntQ <= (postCntQ >= postLimit) ? 2'h0 : postCntQ + 2'h1;
    end
  end

  assign clkTick = oscTick && (postCntQ >= postLimit);

  // output clock and its half-rate companion
  always_ff @(posedge mclk) begin
    if (rst || !synthOn) begin
      fullQ <= 1'b0;
      halfQ <= 1'b0;
    end else if (clkTick) begin
      fullQ <= ~fullQ;
      if (fullQ) begin
        halfQ <= ~halfQ;
      end
    end
  end

  // sync with input polarity removed, positive when bit is one
  assign syncLevel = pinQ[3] ^ ~outPolQ[pcr_pkg::OP_POL_SYNC];

  // coarse delay line in output clock periods; fine part is analogue
  always_ff @(posedge mclk) begin
    if (rst || !synthOn) begin
      delayLineQ <= 4'h0;
      dsyncQ <= 1'b0;
    end else if (clkTick && fullQ) begin
      delayLineQ <= {delayLineQ[2:0], syncLevel};
      dsyncQ <= delayLineQ[delayQ[pcr_pkg::DLY_COARSE_HI:
                                  pcr_pkg::DLY_COARSE_LO]] ^
                ~outPolQ[pcr_pkg::OP_POL_DELAYED_SYNC_OUT];
    end
  end

  // fine code n asks the delay line for (n+1)/16 clock
  assign fineDelayCode = delayQ[pcr_pkg::DLY_FINE_HI:0];

  // pump code 01 is mapped to 00 so it can never reach the pump
  assign pumpCurrent =
    (pumpQ[pcr_pkg::PUMP_CUR_HI:pcr_pkg::PUMP_CUR_LO] ==
     pcr_pkg::PUMP_UNUSED) ? pcr_pkg::PUMP_LOW :
    pumpQ[pcr_pkg::PUMP_CUR_HI:pcr_pkg::PUMP_CUR_LO];

  assign centerBand = centerQ[pcr_pkg::CEN_BAND_HI:0];
  assign phaseDetectorPolarity = testPowQ[pcr_pkg::TP_POL_PD];

  // PECL pairs are always driven
  assign peclFullRate = fullQ;
  assign peclFullRateN = ~fullQ;
  assign peclHalfRate = halfQ;
  assign peclHalfRateN = ~halfQ;
  assign peclDelayedSync = dsyncQ;
  assign peclDelayedSyncN = ~dsyncQ;

  // TTL outputs carry values always; each enable decides the drive
  assign counterTestOut = testOut;
  assign counterTestOe = pumpQ[pcr_pkg::PUMP_EN_TEST];
  assign unlockOut = pinQ[5];
  assign unlockOe = outPolQ[pcr_pkg::OP_EN_UNLOCK];
  assign delayedSyncOut = dsyncQ;
  assign delayedSyncOe = outPolQ[pcr_pkg::OP_EN_DELAYED_SYNC_OUT];
  assign halfRateClockOut = halfQ;
  assign halfRateClockOe = outPolQ[pcr_pkg::OP_EN_HALF];
  assign halfRateClockOutInverted = ~halfQ;
  assign halfRateClockInvOe = outPolQ[pcr_pkg::OP_EN_HALF_N];
  assign fullRateClockOut = fullQ;
  assign fullRateClockOe = outPolQ[pcr_pkg::OP_EN_FULL];
  assign fullRateClockOutInverted = ~fullQ;
  assign fullRateClockInvOe = outPolQ[pcr_pkg::OP_EN_FULL_N];

endmodule

// >>> tb/pcr_host_model.sv
/*
 * host side of the three-line serial bus: framed writes and scans.
 * assumes the device mclk; pins change just after rising edges.
 */
`timescale 1ns/100ps
module pcr_host_model (
  // clock
  input wire logic mclk,
  // bus pins
  output logic serialClock,
  output logic serialData,
  output logic serialFrameEnable,
  input wire logic readbackWire
);
  // idle bus: clock stands low outside frames and scans
  initial begin
    serialClock = 1'b0;
    serialData = 1'b0;
    serialFrameEnable = 1'b0;
  end

  // four mclk per level, one more than the pin synchronisers need
  task automatic hold();
    repeat (4) @(posedge mclk);
  endtask

  // n bits msb first inside one enable window
  task automatic frame(input logic [15:0] bits, input int n);
    serialFrameEnable <= 1'b1;
    hold();
    for (int i = n - 1; i >= 0; i--) begin
      serialData <= bits[i];
      hold();
      serialClock <= 1'b1;
      hold();
      serialClock <= 1'b0;
    end
    hold();
    serialFrameEnable <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask

  // 41 clocks with enable low; bit seen before each rise
  task automatic scan(output logic [40:0] v);
    for (int i = 40; i >= 0; i--) begin
      hold();
      v[i] = readbackWire;
      serialClock <= 1'b1;
      hold();
      serialClock <= 1'b0;
    end
    hold();
  endtask
endmodule

// >>> tb/pcr_control_regs_asserts.sv
/*
 * port checker of the control register bank.
 * assumes one mclk domain with synchronous active-high rst.
 */
`timescale 1ns/100ps
module pcr_control_regs_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // watched pins
  input wire logic serialClock,
  input wire logic serialFrameEnable,
  input wire logic serialReadbackOut,
  input wire logic serialReadbackOe,
  input wire logic [12:0] divideRatio,
  input wire logic [1:0] pumpCurrent,
  input wire logic [4:0] centerBand,
  input wire logic [4:0] fineDelayCode,
  input wire logic synthesizerEnable,
  input wire logic feedbackPulse,
  input wire logic peclFullRate,
  input wire logic peclFullRateN,
  input wire logic peclHalfRate,
  input wire logic peclHalfRateN
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_ratio_floor;
    divideRatio >= 13'h0009;
  endproperty
  a_ratio_floor: assert property (p_ratio_floor)
    else $error("divide ratio below nine");

  property p_pulse_single;
    feedbackPulse |=> !feedbackPulse;
  endproperty
  a_pulse_single: assert property (p_pulse_single)
    else $error("feedback pulse longer than a cycle");

  property p_pump_unused;
    pumpCurrent != 2'h1;
  endproperty
  a_pump_unused: assert property (p_pump_unused)
    else $error("pump code 01 reached the pump");

  property p_pecl_pairs;
    peclFullRateN == !peclFullRate && peclHalfRateN == !peclHalfRate;
  endproperty
  a_pecl_pairs: assert property (p_pecl_pairs)
    else $error("pecl pair not complementary");

  // settings move only after the enable has fallen
  property p_hold_in_frame;
    serialFrameEnable && $past(serialFrameEnable, 6) |->
      $stable({divideRatio, pumpCurrent, centerBand, fineDelayCode});
  endproperty
  a_hold_in_frame: assert property (p_hold_in_frame)
    else $error("setting changed inside a frame");

  property p_synthesizer_enable_off;
    !synthesizerEnable [*3] |->
      !feedbackPulse && !peclFullRate && !peclHalfRate;
  endproperty
  a_synthesizer_enable_off: assert property (p_synthesizer_enable_off)
    else $error("clocks run while synthesizer off");

  property p_half_rate;
    synthesizerEnable && $past(synthesizerEnable) &&
      $changed(peclHalfRate) |-> $changed(peclFullRate);
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("half rate moved without full rate");

  // no sclk rise can be in flight after eight low cycles
  property p_scan_still;
    (serialReadbackOe && !serialFrameEnable && !serialClock) [*8] |->
      $stable(serialReadbackOut);
  endproperty
  a_scan_still: assert property (p_scan_still)
    else $error("readback moved without serial clock");
endmodule

bind pcr_control_regs pcr_control_regs_asserts u_chk (.*);

// >>> tb/pcr_control_regs_tb.sv
/*
 * testbench of the control register bank driven by the host model.
 * assumes the bound checker; timing inputs are held low.
 */
`timescale 1ns/100ps
module pcr_control_regs_tb;
  logic mclk, rst, serialClock, serialData, serialFrameEnable;
  logic serialReadbackOut, serialReadbackOe, syncIn, oscillatorTestIn;
  logic unlockIn, phaseDetectorPolarity, synthesizerEnable, feedbackPulse;
  logic [12:0] divideRatio;
  logic [1:0] pumpCurrent;
  logic [4:0] centerBand, fineDelayCode;
  logic peclFullRate, peclFullRateN, peclHalfRate, peclHalfRateN;
  logic peclDelayedSync, peclDelayedSyncN, counterTestOut, counterTestOe;
  logic unlockOut, unlockOe, delayedSyncOut, delayedSyncOe;
  logic halfRateClockOut, halfRateClockOe, halfRateClockOutInverted;
  logic halfRateClockInvOe, fullRateClockOut, fullRateClockOe;
  logic fullRateClockOutInverted, fullRateClockInvOe, readbackWire, rbHold;
  logic [40:0] img = {8'h38, 4'h5, 7'h5f, 7'h10, 3'h4, 8'h03, 4'h7};
  int wd[8] = '{0, 8, 4, 7, 7, 3, 8, 4};
  int ps[8] = '{0, 33, 29, 22, 15, 12, 4, 0};
  int miscompares = 0;
  int nChecks = 0;

  pcr_control_regs DUT (.*);
  pcr_host_model host (.*);

  // free clock, reset held six cycles
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // released readback pin shows the inverse of its last level
  initial rbHold = 1'b0;
  always @(posedge mclk) if (serialReadbackOe === 1'b1) rbHold <= ~serialReadbackOut;
  assign readbackWire = serialReadbackOe ? serialReadbackOut : rbHold;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [40:0] g, input logic [40:0] e);
    nChecks++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // shadow image follows every write; frame is address then data
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    for (int i = 0; i < wd[a]; i++) img[ps[a] + i] = d[i];
    host.frame((16'(a) << wd[a]) | 16'(d), 3 + wd[a]);
  endtask

  // every decoded setting on a port against the shadow image
  task automatic chk_set();
    logic [1:0] pc;
    pc = img[14:13] == 2'h1 ? 2'h0 : img[14:13];
    chk(divideRatio, {img[32:29], img[40:33]} + 13'h8);
    chk(pumpCurrent, pc);
    chk(centerBand, img[26:22]);
    chk(fineDelayCode, img[19:15]);
    chk({serialReadbackOe, synthesizerEnable, phaseDetectorPolarity},
      {img[3], img[2], img[0]});
    chk({counterTestOe, unlockOe, delayedSyncOe, halfRateClockOe,
      halfRateClockInvOe, fullRateClockOe, fullRateClockInvOe},
      {img[12], img[11:6]});
  endtask

  // distance of two feedback pulses; the first gap may be cut short
  task automatic period(input int e);
    int n;
    repeat (3) begin
      n = 0;
      // sampled mid-cycle so the pulse has settled
      do begin
        @(negedge mclk);
        n++;
      end while (feedbackPulse !== 1'b1 && n < 3000);
    end
    chk(n, e);
  endtask

  task automatic t_divisor();
    wr(3'h1, 8'h01);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h1f);
    period(9);
    wr(3'h3, 8'h3f);
    period(18);
    wr(3'h3, 8'h5f);
    period(36);
    wr(3'h1, 8'hff);
    wr(3'h2, 8'h0e);
    chk_set();
    $display("divisor test done");
  endtask

  // every pump code, walking-one enable patterns, a shifted run of ones for delay
  task automatic t_codes();
    for (int i = 0; i < 8; i++) begin
      wr(3'h5, 8'(i));
      wr(3'h6, 8'h01 << i);
      wr(3'h4, 8'(7'(8'h1f << i)));
      chk_set();
    end
    $display("code test done");
  endtask

  // address zero and a short frame leave everything untouched
  task automatic t_refused();
    host.frame({5'h00, 3'h0, 8'h55}, 11);
    host.frame({12'h000, 3'h1, 1'b0}, 4);
    chk_set();
    $display("refused frame test done");
  endtask

  // synthesizer_enable off, then scan; a second write reloads the image
  task automatic t_scan();
    logic [40:0] v;
    wr(3'h7, 8'h00);
    chk_set();
    wr(3'h7, 8'h0f);
    wr(3'h1, img[40:33]);
    chk_set();
    host.scan(v);
    chk(v, img);
    wr(3'h7, 8'h07);
    chk_set();
    $display("scan test done");
  endtask

  // watchdog well beyond the expected run
  initial begin
    #400000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    syncIn = 1'b0;
    oscillatorTestIn = 1'b0;
    unlockIn = 1'b0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    chk_set();
    $display("reset test done");
    t_divisor();
    t_codes();
    t_refused();
    t_scan();
    report_and_stop();
  end
endmodule
